// file: design/pdf_predriver_fanout.v
`timescale 1ns/1ps
`include "pdf_defs.vh"

// Notes on behaviour
// - seventh low-side output gated by flags, allow
// - seventh low-side rise/fall slopes from register
// - per high-side bootstrap charge block during end
// - high-side drain thresholds, three bits each
// - high-side source thresholds, three bits each
// - six low-side drain thresholds over two registers
// - bias enables; strong bias drivers two, four
// - two-bit gain per current-sense amplifier
// - two-bit gain per analog output buffer
// - five eight-bit DAC levels from registers
// - three-bit negative level for block four
// - accept six comparator results plus block four pair
// - two three-bit analog output mux selects
// - serial output slope bit from serial config
// - missing clock drops drive-allow until switchover
// - clock-lost set while pll clock invalid
// - high-side drivers disabled while clock lost
// - gate supply under flag when supply low
module pdf_predriver_fanout (
    input wire mclk,
    input wire resetn,
    // internal register port from the serial logic
    input wire [9:0] regAddr,
    input wire regWrEn,
    input wire [15:0] regWrData,
    input wire regRdEn,
    output reg [15:0] regRdData,
    // drive requests and phases from the logic core (mclk domain)
    input wire lowSideSevenRequest,
    input wire [4:0] highSideRequest,
    input wire [4:0] endOfDrivePhase,
    // analog status inputs (asynchronous)
    input wire gateSupplyBelow,
    input wire logicSupplyBelow,
    input wire extClockMissing,
    input wire backupSwitchDone,
    input wire pllClockInvalid,
    input wire [5:0] currentCompare,
    input wire block4HighCompare,
    input wire block4LowCompare,
    // drive outputs
    output reg lowSideSevenDriveOut,
    output reg [4:0] highSideDriveOut,
    output reg [1:0] lowSideSevenRiseSlope,
    output reg [1:0] lowSideSevenFallSlope,
    output reg [4:0] bootstrapChargeBlock,
    // monitor thresholds, three bits per driver
    output reg [14:0] highDrainThreshold,
    output reg [14:0] highSourceThreshold,
    output reg [17:0] lowDrainThreshold,
    // bias enables
    output reg [4:0] highBiasEnable,
    output reg [5:0] lowBiasEnable,
    output reg [1:0] highStrongBias,
    // current sense and analog outputs
    output reg [7:0] ampGain,
    output reg [1:0] out1BufferGain,
    output reg [1:0] out2BufferGain,
    output reg [39:0] currentDacLevel,
    output reg [2:0] block4NegativeLevel,
    output reg [2:0] out1MuxSelect,
    output reg [2:0] out2MuxSelect,
    output reg serialSlowSlope,
    // status
    output reg gateSupplyUnder,
    output reg logicSupplyUnder,
    output reg clockValidDriveAllow,
    output reg clockLost,
    output reg [5:0] currentCompareSync,
    output reg block4HighCompareSync,
    output reg block4LowCompareSync
);

    // configuration storage, indexed
    reg [15:0] negLevelCfg;
    reg [15:0] hsDrainCfg;
    reg [15:0] hsSourceCfg;
    reg [15:0] lsDrainCfgA;
    reg [15:0] lsDrainCfgB;
    reg [15:0] lsSlopeCfg;
    reg [15:0] dacCfg [0:4]; // five current DAC level registers
    reg [15:0] serialCfg;
    reg [15:0] biasCfg;
    reg [15:0] gainCfg;
    reg [15:0] outMuxCfg;

    // synchronised analog inputs
    wire [3:0] flagSync; // gate uv, logic uv, ext missing, pll invalid
    wire switchDoneSync;
    wire [7:0] compareSync;
    reg extMissingLast; // edge memory for missing-clock detect
    wire extMissingRise;
    wire [15:0] statusWord;
    integer i;

    // level flags from the analog side
    pdf_sync3 #(
        .W(4)
    ) flagSyncInst (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn({pllClockInvalid, extClockMissing, logicSupplyBelow, gateSupplyBelow}),
        .syncOut(flagSync)
    );

    // switchover completion from the backup clock block
    pdf_sync3 #(
        .W(1)
    ) switchSyncInst (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn(backupSwitchDone),
        .syncOut(switchDoneSync)
    );

    // comparator results from the measurement blocks
    pdf_sync3 #(
        .W(8)
    ) compareSyncInst (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn({block4LowCompare, block4HighCompare, currentCompare}),
        .syncOut(compareSync)
    );

    // register writes; full-word writes only, unmapped writes dropped
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            negLevelCfg <= `PDF_CFG_RESET;
            hsDrainCfg <= `PDF_CFG_RESET;
            hsSourceCfg <= `PDF_CFG_RESET;
            lsDrainCfgA <= `PDF_CFG_RESET;
            lsDrainCfgB <= `PDF_CFG_RESET;
            lsSlopeCfg <= `PDF_CFG_RESET;
            for (i = 0; i < 5; i = i + 1) begin
                dacCfg[i] <= `PDF_CFG_RESET;
            end
            serialCfg <= `PDF_CFG_RESET;
            biasCfg <= `PDF_CFG_RESET;
            gainCfg <= `PDF_CFG_RESET;
            outMuxCfg <= `PDF_CFG_RESET;
        end else if (regWrEn) begin
            case (regAddr)
                `PDF_OFS_NEG_LEVEL: negLevelCfg <= regWrData;
                `PDF_OFS_HS_DRAIN: hsDrainCfg <= regWrData;
                `PDF_OFS_HS_SOURCE: hsSourceCfg <= regWrData;
                `PDF_OFS_LS_DRAIN_A: lsDrainCfgA <= regWrData;
                `PDF_OFS_LS_DRAIN_B: lsDrainCfgB <= regWrData;
                `PDF_OFS_LS_SLOPE: lsSlopeCfg <= regWrData;
                `PDF_OFS_DAC_A: dacCfg[0] <= regWrData;
                `PDF_OFS_DAC_B: dacCfg[1] <= regWrData;
                `PDF_OFS_DAC_C: dacCfg[2] <= regWrData;
                `PDF_OFS_DAC_D: dacCfg[3] <= regWrData;
                `PDF_OFS_DAC_E: dacCfg[4] <= regWrData;
                `PDF_OFS_SERIAL: serialCfg <= regWrData;
                `PDF_OFS_BIAS: biasCfg <= regWrData;
                `PDF_OFS_GAIN: gainCfg <= regWrData;
                `PDF_OFS_OUT_MUX: outMuxCfg <= regWrData;
                default: begin
                    // unmapped address: nothing stored
                end
            endcase
        end
    end

    // live status word: comparators, flags, clock state
    assign statusWord = {3'h0, clockLost, clockValidDriveAllow, logicSupplyUnder,
                         gateSupplyUnder, block4LowCompareSync, block4HighCompareSync,
                         1'b0, currentCompareSync};

    // read data registered one cycle after regRdEn; unmapped reads zero
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 16'h0000;
        end else if (regRdEn) begin
            case (regAddr)
                `PDF_OFS_NEG_LEVEL: regRdData <= negLevelCfg;
                `PDF_OFS_HS_DRAIN: regRdData <= hsDrainCfg;
                `PDF_OFS_HS_SOURCE: regRdData <= hsSourceCfg;
                `PDF_OFS_LS_DRAIN_A: regRdData <= lsDrainCfgA;
                `PDF_OFS_LS_DRAIN_B: regRdData <= lsDrainCfgB;
                `PDF_OFS_LS_SLOPE: regRdData <= lsSlopeCfg;
                `PDF_OFS_DAC_A: regRdData <= dacCfg[0];
                `PDF_OFS_DAC_B: regRdData <= dacCfg[1];
                `PDF_OFS_DAC_C: regRdData <= dacCfg[2];
                `PDF_OFS_DAC_D: regRdData <= dacCfg[3];
                `PDF_OFS_DAC_E: regRdData <= dacCfg[4];
                `PDF_OFS_SERIAL: regRdData <= serialCfg;
                `PDF_OFS_BIAS: regRdData <= biasCfg;
                `PDF_OFS_GAIN: regRdData <= gainCfg;
                `PDF_OFS_OUT_MUX: regRdData <= outMuxCfg;
                `PDF_OFS_STATUS: regRdData <= statusWord;
                default: regRdData <= 16'h0000;
            endcase
        end
    end

    // missing-clock event: only the rising edge drops the allow, so a
    // clock that stays missing after switchover does not block forever
    assign extMissingRise = flagSync[2] & ~extMissingLast;

    // supply flags, clock state and drive-allow
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            extMissingLast <= 1'b0;
            gateSupplyUnder <= 1'b0;
            logicSupplyUnder <= 1'b0;
            clockLost <= 1'b0;
            clockValidDriveAllow <= 1'b1;
        end else begin
            extMissingLast <= flagSync[2];
            gateSupplyUnder <= flagSync[0];
            logicSupplyUnder <= flagSync[1];
            clockLost <= flagSync[3];
            if (extMissingRise) begin
                clockValidDriveAllow <= 1'b0;
            end else if (switchDoneSync) begin
                clockValidDriveAllow <= 1'b1;
            end
        end
    end

    // pre-drive gating; high-side drive drops on any blocking condition, low-side seven ignores clockLost, bootstrap follows endOfDrivePhase ungated
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lowSideSevenDriveOut <= 1'b0;
            highSideDriveOut <= 5'h00;
            bootstrapChargeBlock <= 5'h00;
        end else begin
            lowSideSevenDriveOut <= lowSideSevenRequest & ~gateSupplyUnder & ~logicSupplyUnder
                                    & clockValidDriveAllow;
            highSideDriveOut <= highSideRequest & {5{~gateSupplyUnder & ~logicSupplyUnder
                                & clockValidDriveAllow & ~clockLost}};
            bootstrapChargeBlock <= endOfDrivePhase;
        end
    end

    // configuration fan-out to the analog front end
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lowSideSevenRiseSlope <= 2'h0;
            lowSideSevenFallSlope <= 2'h0;
            highDrainThreshold <= 15'h0000;
            highSourceThreshold <= 15'h0000;
            lowDrainThreshold <= 18'h00000;
            highBiasEnable <= 5'h00;
            lowBiasEnable <= 6'h00;
            highStrongBias <= 2'h0;
            ampGain <= 8'h00;
            out1BufferGain <= 2'h0;
            out2BufferGain <= 2'h0;
            currentDacLevel <= 40'h0000000000;
            block4NegativeLevel <= 3'h0;
            out1MuxSelect <= 3'h0;
            out2MuxSelect <= 3'h0;
            serialSlowSlope <= 1'b0;
            currentCompareSync <= 6'h00;
            block4HighCompareSync <= 1'b0;
            block4LowCompareSync <= 1'b0;
        end else begin
            lowSideSevenRiseSlope <= lsSlopeCfg[`PDF_RISE_LSB +: 2];
            lowSideSevenFallSlope <= lsSlopeCfg[`PDF_FALL_LSB +: 2];
            highDrainThreshold <= hsDrainCfg[14:0];
            highSourceThreshold <= hsSourceCfg[14:0];
            // drivers one to five in the first register, six in the second
            lowDrainThreshold <= {lsDrainCfgB[2:0], lsDrainCfgA[14:0]};
            highBiasEnable <= biasCfg[`PDF_HS_BIAS_LSB +: 5];
            lowBiasEnable <= biasCfg[`PDF_LS_BIAS_LSB +: 6];
            // bit 0 is high driver two, bit 1 high driver four
            highStrongBias <= biasCfg[`PDF_STRONG_LSB +: 2];
            ampGain <= gainCfg[`PDF_AMP_GAIN_LSB +: 8];
            out1BufferGain <= gainCfg[`PDF_OUT1_GAIN_LSB +: 2];
            out2BufferGain <= gainCfg[`PDF_OUT2_GAIN_LSB +: 2];
            for (i = 0; i < 5; i = i + 1) begin
                currentDacLevel[i*8 +: 8] <= dacCfg[i][7:0];
            end
            block4NegativeLevel <= negLevelCfg[2:0];
            out1MuxSelect <= outMuxCfg[`PDF_OUT1_SEL_LSB +: 3];
            out2MuxSelect <= outMuxCfg[`PDF_OUT2_SEL_LSB +: 3];
            serialSlowSlope <= serialCfg[`PDF_SERIAL_SLOPE_BIT];
            currentCompareSync <= compareSync[5:0];
            block4HighCompareSync <= compareSync[6];
            block4LowCompareSync <= compareSync[7];
        end
    end

endmodule // pdf_predriver_fanout

// file: design/pdf_defs.vh
`ifndef PDF_DEFS_VH
`define PDF_DEFS_VH

// register offsets on the internal register port (10-bit word address)
`define PDF_ADDR_W 10
`define PDF_DATA_W 16
`define PDF_OFS_NEG_LEVEL 10'h01a
`define PDF_OFS_HS_DRAIN 10'h18a
`define PDF_OFS_HS_SOURCE 10'h18b
`define PDF_OFS_LS_DRAIN_A 10'h18c
`define PDF_OFS_LS_DRAIN_B 10'h18d
`define PDF_OFS_LS_SLOPE 10'h18f
`define PDF_OFS_DAC_A 10'h19e
`define PDF_OFS_DAC_B 10'h19f
`define PDF_OFS_DAC_C 10'h1a0
`define PDF_OFS_DAC_D 10'h1a1
`define PDF_OFS_DAC_E 10'h1a2
`define PDF_OFS_SERIAL 10'h1c8
`define PDF_OFS_BIAS 10'h1f0
`define PDF_OFS_GAIN 10'h1f1
`define PDF_OFS_OUT_MUX 10'h1f2
`define PDF_OFS_STATUS 10'h1f3

// field positions
`define PDF_RISE_LSB 0
`define PDF_FALL_LSB 2
`define PDF_SERIAL_SLOPE_BIT 0
`define PDF_HS_BIAS_LSB 0
`define PDF_LS_BIAS_LSB 5
`define PDF_STRONG_LSB 11
`define PDF_AMP_GAIN_LSB 0
`define PDF_OUT1_GAIN_LSB 8
`define PDF_OUT2_GAIN_LSB 10
`define PDF_OUT1_SEL_LSB 0
`define PDF_OUT2_SEL_LSB 3

// reset value of every configuration register
`define PDF_CFG_RESET 16'h0000

`endif

// file: design/pdf_sync3.v
`timescale 1ns/1ps

// three-stage synchroniser for inputs from outside the mclk domain;
// the output moves only when stages two and three agree on a bit
module pdf_sync3 #(
    parameter W = 1
) (
    input wire mclk,
    input wire resetn,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut
);

    reg [W-1:0] stageOne; // metastability catcher, read by stageTwo only
    reg [W-1:0] stageTwo;
    reg [W-1:0] stageThree;

    // shift chain plus agreement filter
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stageOne <= {W{1'b0}};
            stageTwo <= {W{1'b0}};
            stageThree <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            stageOne <= asyncIn;
            stageTwo <= stageOne;
            stageThree <= stageTwo;
            // agree: take value; disagree: hold previous
            syncOut <= (stageTwo & stageThree) | (syncOut & (stageTwo | stageThree));
        end
    end

endmodule // pdf_sync3

// file: tb/pdf_predriver_fanout_properties.sv
`timescale 1ns/1ps
`include "pdf_defs.vh"

// port-level checks of the fan-out block, all in the mclk domain
module pdf_predriver_fanout_properties (
    input wire mclk,
    input wire resetn,
    input wire [9:0] regAddr,
    input wire regWrEn,
    input wire [15:0] regWrData,
    input wire lowSideSevenRequest,
    input wire [4:0] highSideRequest,
    input wire [4:0] endOfDrivePhase,
    input wire gateSupplyBelow,
    input wire extClockMissing,
    input wire backupSwitchDone,
    input wire pllClockInvalid,
    input wire lowSideSevenDriveOut,
    input wire [4:0] highSideDriveOut,
    input wire [1:0] lowSideSevenRiseSlope,
    input wire [1:0] lowSideSevenFallSlope,
    input wire [4:0] bootstrapChargeBlock,
    input wire serialSlowSlope,
    input wire gateSupplyUnder,
    input wire logicSupplyUnder,
    input wire clockValidDriveAllow,
    input wire clockLost
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // permission shared by the ls7 and high-side drive outputs
    wire okAll = ~gateSupplyUnder & ~logicSupplyUnder & clockValidDriveAllow;
    // one write strobe at a given offset
    sequence s_wr(ofs);
        regWrEn && regAddr == ofs;
    endsequence
    // clock lost and backup not yet running for six cycles
    sequence s_miss;
        $rose(extClockMissing) ##1 !backupSwitchDone [*6];
    endsequence
    property p_ls7;
        lowSideSevenDriveOut == $past(lowSideSevenRequest & okAll);
    endproperty
    property p_hs;
        highSideDriveOut == $past(highSideRequest & {5{okAll & ~clockLost}});
    endproperty
    property p_boot;
        bootstrapChargeBlock == $past(endOfDrivePhase);
    endproperty
    property p_slope;
        s_wr(`PDF_OFS_LS_SLOPE) |-> ##2
            {lowSideSevenFallSlope, lowSideSevenRiseSlope} == $past(regWrData[3:0], 2);
    endproperty
    property p_serial;
        s_wr(`PDF_OFS_SERIAL) |-> ##2 serialSlowSlope == $past(regWrData[0], 2);
    endproperty
    property p_allow;
        s_miss |-> !clockValidDriveAllow;
    endproperty
    property p_lost;
        pllClockInvalid [*7] |-> clockLost;
    endproperty
    property p_gate;
        gateSupplyBelow [*7] |-> gateSupplyUnder;
    endproperty
    a_ls7: assert property (p_ls7) else $error("ls7 drive wrong");
    a_hs: assert property (p_hs) else $error("high drive wrong");
    a_boot: assert property (p_boot) else $error("bootstrap block wrong");
    a_slope: assert property (p_slope) else $error("slope fields wrong");
    a_serial: assert property (p_serial) else $error("serial slope wrong");
    a_allow: assert property (p_allow) else $error("drive allow stayed high");
    a_lost: assert property (p_lost) else $error("clock lost missing");
    a_gate: assert property (p_gate) else $error("gate under missing");
endmodule // pdf_predriver_fanout_properties

bind pdf_predriver_fanout pdf_predriver_fanout_properties u_props (.mclk, .resetn,
    .regAddr, .regWrEn, .regWrData, .lowSideSevenRequest, .highSideRequest,
    .endOfDrivePhase, .gateSupplyBelow, .extClockMissing, .backupSwitchDone,
    .pllClockInvalid, .lowSideSevenDriveOut, .highSideDriveOut, .lowSideSevenRiseSlope,
    .lowSideSevenFallSlope, .bootstrapChargeBlock, .serialSlowSlope, .gateSupplyUnder,
    .logicSupplyUnder, .clockValidDriveAllow, .clockLost);

// file: tb/pdf_analog_model.sv
`timescale 1ns/1ps

// analog side: rails, clock source, current comparators
module pdf_analog_model #(
    parameter SWITCH_NS = 80
) (
    input wire dropGate,
    input wire dropLogic,
    input wire loseExt,
    input wire [7:0] sense,
    input wire [39:0] dac,
    input wire [2:0] negLvl,
    output wire gateBelow,
    output wire logicBelow,
    output reg switchDone,
    output wire pllBad,
    output reg [5:0] cmp,
    output wire cmpHigh,
    output wire cmpLow
);
    integer i;
    assign gateBelow = dropGate;
    assign logicBelow = dropLogic;
    // backup oscillator needs time to take over
    initial switchDone = 1'b0;
    always @(loseExt) switchDone <= #(SWITCH_NS) loseExt;
    // no usable clock between the loss and the switchover
    assign pllBad = loseExt & ~switchDone;
    // blocks one to five compare sensed current with their dac levels
    always @* begin
        for (i = 0; i < 5; i = i + 1) begin
            cmp[i] = sense > dac[8*i +: 8];
        end
        cmp[5] = |sense; // zero-current detector
    end
    assign cmpHigh = sense > dac[31:24];
    assign cmpLow = sense < {negLvl, 5'h00};
endmodule // pdf_analog_model

// file: tb/pdf_predriver_fanout_tb.sv
`timescale 1ns/1ps
`include "pdf_defs.vh"

// register and drive-path tests for the fan-out block
module pdf_predriver_fanout_tb;
    reg mclk = 0, resetn = 0, regWrEn = 0, regRdEn = 0, lowSideSevenRequest = 0;
    reg dropGate = 0, dropLogic = 0, extClockMissing = 0;
    reg [9:0] regAddr = 0;
    reg [15:0] regWrData = 0;
    reg [4:0] highSideRequest = 0, endOfDrivePhase = 0;
    reg [7:0] sense = 0;
    wire gateSupplyBelow, logicSupplyBelow, backupSwitchDone, pllClockInvalid, serialSlowSlope;
    wire block4HighCompare, block4LowCompare, lowSideSevenDriveOut, gateSupplyUnder, clockLost;
    wire logicSupplyUnder, clockValidDriveAllow, block4HighCompareSync, block4LowCompareSync;
    wire [5:0] currentCompare, currentCompareSync, lowBiasEnable;
    wire [15:0] regRdData;
    wire [4:0] highSideDriveOut, bootstrapChargeBlock, highBiasEnable;
    wire [1:0] lowSideSevenRiseSlope, lowSideSevenFallSlope, highStrongBias;
    wire [1:0] out1BufferGain, out2BufferGain;
    wire [14:0] highDrainThreshold, highSourceThreshold;
    wire [17:0] lowDrainThreshold;
    wire [7:0] ampGain;
    wire [39:0] currentDacLevel;
    wire [2:0] block4NegativeLevel, out1MuxSelect, out2MuxSelect;
    integer n_mismatch = 0, num_checks = 0, k;
    reg [25:0] tbl [0:11]; // offset and value per register
    pdf_predriver_fanout u_dut (.mclk, .resetn, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData, .lowSideSevenRequest, .highSideRequest, .endOfDrivePhase,
        .gateSupplyBelow, .logicSupplyBelow, .extClockMissing, .backupSwitchDone,
        .pllClockInvalid, .currentCompare, .block4HighCompare, .block4LowCompare,
        .lowSideSevenDriveOut, .highSideDriveOut, .lowSideSevenRiseSlope,
        .lowSideSevenFallSlope, .bootstrapChargeBlock, .highDrainThreshold,
        .highSourceThreshold, .lowDrainThreshold, .highBiasEnable, .lowBiasEnable,
        .highStrongBias, .ampGain, .out1BufferGain, .out2BufferGain, .currentDacLevel,
        .block4NegativeLevel, .out1MuxSelect, .out2MuxSelect, .serialSlowSlope,
        .gateSupplyUnder, .logicSupplyUnder, .clockValidDriveAllow, .clockLost,
        .currentCompareSync, .block4HighCompareSync, .block4LowCompareSync);
    pdf_analog_model u_afe (.dropGate(dropGate), .dropLogic(dropLogic),
        .loseExt(extClockMissing), .sense(sense), .dac(currentDacLevel),
        .negLvl(block4NegativeLevel), .gateBelow(gateSupplyBelow),
        .logicBelow(logicSupplyBelow), .switchDone(backupSwitchDone),
        .pllBad(pllClockInvalid), .cmp(currentCompare), .cmpHigh(block4HighCompare),
        .cmpLow(block4LowCompare));
    always #2 mclk = ~mclk;
    task check(input [39:0] seen, input [39:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one strobe cycle, released at the next falling edge
    task acc(input w, input [9:0] a, input [15:0] d);
        begin
            @(negedge mclk);
            regAddr = a;
            regWrData = d;
            regWrEn = w;
            regRdEn = ~w;
            @(negedge mclk);
            regWrEn = 0;
            regRdEn = 0;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge mclk);
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        tbl[0] = {`PDF_OFS_NEG_LEVEL, 16'h0005};
        tbl[1] = {`PDF_OFS_HS_DRAIN, 16'h5391};
        tbl[2] = {`PDF_OFS_HS_SOURCE, 16'h2c6e};
        tbl[3] = {`PDF_OFS_LS_DRAIN_A, 16'h7fa3};
        tbl[4] = {`PDF_OFS_LS_DRAIN_B, 16'h0006};
        tbl[5] = {`PDF_OFS_LS_SLOPE, 16'h000d};
        // keep both halves 10 and 16 bits wide so the offset survives the concat
        for (k = 0; k < 5; k = k + 1) tbl[6+k] = {10'h19e + k[9:0], 16'h0011 + 16'h0049 * k[15:0]};
        tbl[11] = {`PDF_OFS_SERIAL, 16'h0001};
        cyc(12);
        resetn = 1;
        for (k = 0; k < 12; k = k + 1) begin
            acc(0, tbl[k][25:16], 0);
            check(regRdData, `PDF_CFG_RESET);
            acc(1, tbl[k][25:16], tbl[k][15:0]);
            acc(0, tbl[k][25:16], 0);
            check(regRdData, tbl[k][15:0]);
        end
        acc(1, `PDF_OFS_BIAS, 16'h0abc);
        acc(1, `PDF_OFS_GAIN, 16'h0b6c);
        acc(1, `PDF_OFS_OUT_MUX, 16'h0035);
        acc(1, 10'h100, 16'hffff);
        acc(0, 10'h100, 0);
        check(regRdData, 0);
        cyc(2);
        check({lowSideSevenFallSlope, lowSideSevenRiseSlope}, 4'hd);
        check({highSourceThreshold, highDrainThreshold}, {15'h2c6e, 15'h5391});
        check(lowDrainThreshold, {3'h6, 15'h7fa3});
        check({highStrongBias, lowBiasEnable, highBiasEnable}, 13'h0abc);
        check(ampGain, 8'h6c);
        check({out2BufferGain, out1BufferGain}, 4'hb);
        check(currentDacLevel, 40'h35_ec_a3_5a_11);
        check(block4NegativeLevel, 3'h5);
        check({out2MuxSelect, out1MuxSelect}, 6'h35);
        check(serialSlowSlope, 1);
        $display("test registers done");
        lowSideSevenRequest = 1;
        highSideRequest = 5'h15;
        endOfDrivePhase = 5'h0a;
        cyc(2);
        check({lowSideSevenDriveOut, highSideDriveOut}, 6'h35);
        check(bootstrapChargeBlock, 5'h0a);
        dropGate = 1;
        cyc(8);
        check({gateSupplyUnder, lowSideSevenDriveOut, highSideDriveOut}, 7'h40);
        dropGate = 0;
        dropLogic = 1;
        cyc(8);
        check({logicSupplyUnder, gateSupplyUnder, lowSideSevenDriveOut}, 3'h4);
        dropLogic = 0;
        cyc(8);
        check(lowSideSevenDriveOut, 1);
        $display("test supply gating done");
        extClockMissing = 1;
        cyc(8);
        check({clockValidDriveAllow, clockLost, highSideDriveOut}, 7'h20);
        cyc(30);
        check({clockValidDriveAllow, clockLost, highSideDriveOut}, 7'h55);
        extClockMissing = 0;
        $display("test clock loss done");
        sense = 8'h60;
        cyc(8);
        check({block4LowCompareSync, block4HighCompareSync, currentCompareSync}, 8'hb3);
        sense = 8'hff;
        cyc(8);
        acc(1, `PDF_OFS_STATUS, 0);
        acc(0, `PDF_OFS_STATUS, 0);
        check(regRdData, 16'h08bf);
        $display("test comparators done");
        results;
    end
    initial begin
        #20000;
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t watchdog expired", $time);
        results;
    end
endmodule // pdf_predriver_fanout_tb
